/* lcsc_host.sv */
// host model: select and serial clock frames
`timescale 1ns/100ps
`default_nettype none
module lcsc_host (
  // frame request
  input  wire logic       go,
  input  wire logic [3:0] n_pulses,
  // serial pins
  output var  logic       select_b,
  output var  logic       link_clk
);
  initial begin
    select_b = 1'b1;
    link_clk = 1'b0;
  end
  always @(posedge go) begin
    select_b = 1'b0;
    #153;
    repeat (n_pulses) begin
      link_clk = 1'b1;
      #32 link_clk = 1'b0;
      #32;
    end
    #117 select_b = 1'b1;
  end
endmodule : lcsc_host
`default_nettype wire

/* lcsc_pkg.sv */
// constants and types for the led current level serial control
package lcsc_pkg;
  localparam int          LEVEL_W      = 7;
  localparam int          CNT_W        = 4;
  localparam int          RATIO_W      = 14;
  localparam logic [6:0]  LEVEL_RST    = 7'h00;
  localparam logic [3:0]  OVF_LIMIT    = 4'h8;
  localparam logic [13:0] RATIO_K      = 14'h02EA;
  localparam int          CLK_MHZ      = 50;
  localparam int          CLEAR_NS     = 20;
  localparam int          CLEAR_CYC_RAW = (CLEAR_NS * CLK_MHZ) / 1000;
  localparam int          CLEAR_CYC    = (CLEAR_CYC_RAW < 1) ? 1 :
                                         CLEAR_CYC_RAW;

  typedef struct packed {
    logic [3:0] count;
    logic [3:0] gray;
  } lcsc_link_type;

  typedef struct packed {
    logic        cs_s1;
    logic        cs_s2;
    logic        cs_p;
    logic        loc_s1;
    logic        loc_s2;
    logic [3:0]  gray_s1;
    logic [3:0]  gray_s2;
    logic [3:0]  base;
    logic        ovf;
    logic [6:0]  level;
    logic        shutdown;
    logic [13:0] ratio_x2;
    logic        out_on;
  } lcsc_sys_type;
endpackage : lcsc_pkg

/* lcsc_top.sv */
// serial current level control: link counter and level latch
`timescale 1ns/100ps
`default_nettype none
module lcsc_top
  import lcsc_pkg::*;
(
  // system clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  // serial link pins and mode select
  input  wire logic               link_clk,
  input  wire logic               select_b,
  input  wire logic               mode_serial,
  // current control outputs
  output var  logic [LEVEL_W-1:0] level_bits,
  output var  logic [RATIO_W-1:0] ratio_x2,
  output var  logic               out_on
);

  lcsc_link_type lnk_q, lnk_d;
  lcsc_sys_type  sys_q, sys_d;

  function automatic logic [3:0] gray2bin(input logic [3:0] g);
    logic [3:0] b;
    b[3] = g[3];
    b[2] = b[3] ^ g[2];
    b[1] = b[2] ^ g[1];
    b[0] = b[1] ^ g[0];
    return b;
  endfunction : gray2bin

  // link domain pulse counter
  always_comb begin
    lnk_d = lnk_q;
    if (!select_b) begin
      lnk_d.count = lnk_q.count + 4'h1;
    end
    lnk_d.gray = lnk_d.count ^ (lnk_d.count >> 1);
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      lnk_q <= '0;
    end else begin
      lnk_q <= lnk_d;
    end
  end

  logic [3:0] cur_bin;
  logic [3:0] delta;
  logic [2:0] idx;
  logic       fall_ev;
  logic       rise_ev;

  always_comb begin
    sys_d         = sys_q;
    sys_d.cs_s1   = select_b;
    sys_d.cs_s2   = sys_q.cs_s1;
    sys_d.cs_p    = sys_q.cs_s2;
    sys_d.loc_s1  = mode_serial;
    sys_d.loc_s2  = sys_q.loc_s1;
    sys_d.gray_s1 = lnk_q.gray;
    sys_d.gray_s2 = sys_q.gray_s1;
    cur_bin       = gray2bin(sys_q.gray_s2);
    delta         = cur_bin - sys_q.base;
    fall_ev       = sys_q.cs_p && !sys_q.cs_s2;
    rise_ev       = !sys_q.cs_p && sys_q.cs_s2;
    idx           = 3'h0;
    if (fall_ev) begin
      sys_d.base = cur_bin;
      sys_d.ovf  = 1'b0;
    end else if (!sys_q.cs_s2 && delta > OVF_LIMIT) begin
      sys_d.ovf = 1'b1;
    end
    if (rise_ev && sys_q.loc_s2) begin
      if (sys_q.ovf || delta > OVF_LIMIT) begin
        sys_d.level    = LEVEL_RST;
        sys_d.shutdown = 1'b1;
      end else begin
        sys_d.level    = (delta >= 4'h1 && delta <= 4'h7) ?
                         7'(7'h01 << (delta - 4'h1)) : LEVEL_RST;
        sys_d.shutdown = 1'b0;
      end
    end
    for (int i = 0; i < LEVEL_W; i++) begin
      if (sys_d.level[i]) begin
        idx = 3'(i + 1);
      end
    end
    if (!sys_q.loc_s2) begin
      sys_d.out_on   = !sys_q.cs_s2;
      sys_d.ratio_x2 = sys_q.cs_s2 ? 14'h0000 : 14'(RATIO_K << 1);
    end else begin
      sys_d.out_on   = !sys_d.shutdown;
      // ratio k times index plus half
      sys_d.ratio_x2 = sys_d.shutdown ? 14'h0000 :
                       14'(RATIO_K * {10'h000, idx, 1'b1});
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sys_q        <= '0;
      sys_q.cs_s1  <= 1'b1;
      sys_q.cs_s2  <= 1'b1;
      sys_q.cs_p   <= 1'b1;
      sys_q.loc_s1 <= 1'b1;
      sys_q.loc_s2 <= 1'b1;
      sys_q.level  <= LEVEL_RST;
    end else begin
      sys_q <= sys_d;
    end
  end

  assign level_bits = sys_q.level;
  assign ratio_x2   = sys_q.ratio_x2;
  assign out_on     = sys_q.out_on;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // rule checks
  AST_MODE_LOW_ON: assert property (
    !sys_q.loc_s2 && !sys_q.cs_s2 |=> out_on)
    else $error("mode low select low not on");

  AST_MODE_LOW_OFF: assert property (
    !sys_q.loc_s2 && sys_q.cs_s2 |=> !out_on && ratio_x2 == 14'h0000)
    else $error("mode low select high not off");

  AST_FIXED: assert property (
    !sys_q.loc_s2 && !sys_q.cs_s2 |=> ratio_x2 == 14'h05D4)
    else $error("fixed ratio wrong");

  AST_LATCH_ONLY_RISE: assert property (
    !rise_ev |=> $stable(level_bits))
    else $error("level changed without select rise");

  AST_CLEAR: assert property (
    fall_ev |=> sys_q.base == $past(cur_bin) && !sys_q.ovf)
    else $error("frame not cleared");

  AST_RATIO: assert property (
    $past(rst_b) && sys_q.loc_s2 && !sys_d.shutdown |=> ratio_x2 ==
      14'(RATIO_K * {10'h000, $past(idx), 1'b1}))
    else $error("ratio mismatch");

  AST_TOP: assert property (
    $past(sys_q.loc_s2) && level_bits == 7'h40 |-> ratio_x2 == 14'h2BB6)
    else $error("top level ratio wrong");

  AST_SHIFT: assert property (
    rise_ev && sys_q.loc_s2 && !sys_q.ovf && delta == 4'h3
      |=> level_bits == 7'h04)
    else $error("three clocks not level three");

  AST_OVF: assert property (
    rise_ev && sys_q.loc_s2 && (sys_q.ovf || delta > OVF_LIMIT)
      |=> level_bits == 7'h00 ##1 !out_on)
    else $error("overflow not shut down");

  AST_ONEHOT: assert property (
    $onehot0(level_bits))
    else $error("level bits not one hot");

  AST_RESET_LEVEL: assert property (
    @(posedge clk) disable iff (1'b0)
    !rst_b |=> level_bits == 7'h00)
    else $error("level not zero after reset");

  AST_SERIAL_ON: assert property (
    $past(rst_b) && $past(sys_q.loc_s2) |-> out_on == !sys_q.shutdown)
    else $error("serial mode output enable wrong");

  AST_SHUT_ZERO: assert property (
    $past(sys_q.loc_s2) && sys_q.shutdown |-> ratio_x2 == 14'h0000)
    else $error("shutdown ratio not zero");

  AST_OVF_STICKY: assert property (
    !sys_q.cs_s2 && !fall_ev && delta > OVF_LIMIT |=> sys_q.ovf)
    else $error("overflow not held");

  AST_COUNT_STEP: assert property (
    @(posedge link_clk) !select_b |=> lnk_q.count ==
      4'($past(lnk_q.count) + 4'h1))
    else $error("link pulse not counted once");

  // main scenarios
  COV_LEVEL7: cover property (rise_ev ##1 level_bits == 7'h40);

  COV_OVF: cover property (rise_ev && sys_q.ovf);

  COV_LOCAL: cover property (!sys_q.loc_s2 && out_on);

  COV_LEVEL1: cover property (rise_ev ##1 level_bits == 7'h01);

  COV_ZERO_PULSE: cover property (rise_ev && delta == 4'h0);

endmodule : lcsc_top
`default_nettype wire

/* lcsc_top_test.sv */
// self-checking bench for the level control
`timescale 1ns/100ps
`default_nettype none
module lcsc_top_test;
  import lcsc_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, go = 1'b0, mode = 1'b1;
  logic sel_b, lclk, on;
  logic [3:0] npul = 4'h0;
  logic [LEVEL_W-1:0] lvl;
  logic [RATIO_W-1:0] rat;
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  int e_bits = 0, e_rat = 746, e_on = 1;
  always #10 clk = ~clk;
  lcsc_host HOST (.go(go), .n_pulses(npul), .select_b(sel_b),
    .link_clk(lclk));
  lcsc_top DUT (.clk(clk), .rst_b(rst_b), .link_clk(lclk),
    .select_b(sel_b), .mode_serial(mode), .level_bits(lvl),
    .ratio_x2(rat), .out_on(on));
  task automatic check(string name, logic [13:0] seen, logic [13:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s exp %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  task automatic cmp();
    @(negedge clk);
    check("level_bits", {7'h00, lvl}, e_bits[13:0]);
    check("ratio_x2", rat, e_rat[13:0]);
    check("out_on", {13'h0000, on}, e_on[13:0]);
    @(posedge clk);
  endtask : cmp
  // one frame, level held mid-frame in serial mode, fixed ratio and on in local mode
  task automatic frame(int n);
    npul <= n[3:0];
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    if (mode) begin
      check("level_bits", {7'h00, lvl}, e_bits[13:0]);
    end else begin
      check("ratio_x2", rat, 14'h05D4);
      check("out_on", {13'h0000, on}, 14'h0001);
    end
    repeat (52) @(posedge clk);
  endtask : frame
  task automatic serial(int n);
    int k;
    frame(n);
    k = (n >= 1 && n <= 7) ? n : 0;
    e_bits = k ? (1 << (k - 1)) : 0;
    e_rat = (n > 8) ? 0 : 746 * (2 * k + 1);
    e_on = (n > 8) ? 0 : 1;
    cmp();
  endtask : serial
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(32'hE328));
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    cmp();
    for (int n = 0; n <= 9; n++) serial(n);
    repeat (12) serial($urandom_range(0, 10));
    mode <= 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    check("ratio_x2", rat, 14'h0000);
    @(posedge clk);
    frame(5);
    @(negedge clk);
    check("ratio_x2", rat, 14'h0000);
    check("out_on", {13'h0000, on}, 14'h0000);
    check("level_bits", {7'h00, lvl}, e_bits[13:0]);
    give_verdict();
  end
endmodule : lcsc_top_test
`default_nettype wire
